/* File: dv/ibri_asserts.sv */
// port-level checker for the remote interface top module
// assumes it is bound onto every ibri_top instance, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ibri_asserts (
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic       avs_read,
   input wire logic       avs_waitrequest,
   input wire logic [7:0] dio_oe,
   input wire logic       dav_oe,
   input wire logic       nrfd_oe,
   input wire logic       ndac_oe,
   input wire logic       ren_n_in,
   input wire logic       panel_key_valid,
   input wire logic       panel_key_pass,
   input wire logic       remote_led,
   input wire logic       lockout,
   input wire logic       compat_toggle,
   input wire logic       lang_toggle,
   input wire logic       compat_mode,
   input wire logic       cmd_lang,
   input wire logic       module_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   read_answer_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered after one cycle");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   accept_order_a: assert property ($rose(nrfd_oe) |=> !ndac_oe)
      else $error("ndac not released after capture");
   source_hold_a: assert property (dav_oe && $past(dav_oe) |-> $stable(dio_oe))
      else $error("data changed while valid");
   clear_compat_a: assert property (module_reset |-> compat_mode)
      else $error("module reset without compat mode");
   clear_pulse_a: assert property (module_reset |=> !module_reset)
      else $error("module reset longer than one cycle");
   key_local_a: assert property (panel_key_valid && !remote_led |=> panel_key_pass)
      else $error("key dropped in local mode");
   key_remote_a: assert property (panel_key_valid && remote_led |=> !panel_key_pass)
      else $error("key passed in remote mode");
   ren_local_a: assert property (ren_n_in [*4] |=> !remote_led && !lockout)
      else $error("remote kept without enable line");
   compat_flip_a: assert property (compat_toggle |=> compat_mode != $past(compat_mode))
      else $error("compat setting did not flip");
   lang_flip_a: assert property (lang_toggle |=> cmd_lang != $past(cmd_lang))
      else $error("language setting did not flip");
endmodule : ibri_asserts
bind ibri_top ibri_asserts chk_u (.clock, .rstn, .avs_read, .avs_waitrequest, .dio_oe, .dav_oe, .nrfd_oe,
   .ndac_oe, .ren_n_in, .panel_key_valid, .panel_key_pass, .remote_led, .lockout, .compat_toggle,
   .lang_toggle, .compat_mode, .cmd_lang, .module_reset);
`default_nettype wire

/* File: dv/ibri_host.sv */
// bus controller model on the far side of the instrument bus pins
// assumes enable high pulls a line low; lines have pull-ups
`timescale 1ns/100ps
`default_nettype none
module ibri_host (
   input  wire logic       clock,
   input  wire logic [7:0] dio_oe,
   input  wire logic       dav_oe,
   input  wire logic       nrfd_oe,
   input  wire logic       ndac_oe,
   input  wire logic       eoi_oe,
   output var  logic [7:0] dio_n_in,
   output var  logic       dav_n_in,
   output var  logic       nrfd_n_in,
   output var  logic       ndac_n_in,
   output var  logic       eoi_n_in,
   output var  logic       atn_n_in,
   output var  logic       ren_n_in
);
   logic [7:0] h_dio = 8'h00;
   logic       h_dav = 0, h_eoi = 0, h_atn = 0, h_ren = 0, h_nrfd = 1, h_ndac = 1;
   // wired-or of both parties, released lines float high
   assign dio_n_in  = ~(dio_oe | h_dio);
   assign dav_n_in  = ~(dav_oe | h_dav);
   assign nrfd_n_in = ~(nrfd_oe | h_nrfd);
   assign ndac_n_in = ~(ndac_oe | h_ndac);
   assign eoi_n_in  = ~(eoi_oe | h_eoi);
   assign atn_n_in  = ~h_atn;
   assign ren_n_in  = ~h_ren;
   // source side, end flag with last byte
   task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
      h_nrfd <= 1'b0;
      h_ndac <= 1'b0;
      h_atn  <= atn;
      repeat (4) @(posedge clock);
      while (nrfd_n_in !== 1'b1) @(posedge clock);
      h_dio <= b;
      h_eoi <= eoi;
      repeat (2) @(posedge clock);
      h_dav <= 1'b1;
      @(posedge clock);
      while (ndac_n_in !== 1'b1) @(posedge clock);
      h_dav <= 1'b0;
      h_dio <= 8'h00;
      h_eoi <= 1'b0;
      repeat (6) @(posedge clock);
      h_atn  <= 1'b0;
      h_nrfd <= 1'b1;
      h_ndac <= 1'b1;
      @(posedge clock);
   endtask : send
   // acceptor side, holds the talker off until called
   task automatic recv(output logic [7:0] b, output logic e);
      h_nrfd <= 1'b0;
      while (dav_n_in !== 1'b0) @(posedge clock);
      b = ~dio_n_in;
      e = ~eoi_n_in;
      h_nrfd <= 1'b1;
      h_ndac <= 1'b0;
      while (dav_n_in !== 1'b1) @(posedge clock);
      h_ndac <= 1'b1;
   endtask : recv
endmodule : ibri_host
`default_nettype wire

/* File: dv/ibri_top_bench.sv */
// self-checking bench: register bus plus controller model
// assumes ibri_host and the checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
module ibri_top_bench;
   import ibri_pkg::*;
   logic        clock = 0, rstn = 0, avs_read = 0, avs_write = 0, ifc_n_in = 1, mr_seen = 0, kp_seen = 0;
   logic        panel_key_valid = 0, panel_key_local = 0, compat_toggle = 0, lang_toggle = 0, e;
   logic        avs_waitrequest, irq, od_level, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, panel_key_pass;
   logic        remote_led, lockout, compat_mode, cmd_lang, module_reset, dav_n_in, nrfd_n_in, ndac_n_in;
   logic        eoi_n_in, atn_n_in, ren_n_in;
   logic [7:0]  avs_address = 0, dio_oe, dio_n_in, b;
   logic [31:0] avs_writedata = 0, avs_readdata, rd;
   int          failures = 0, total_checks = 0;
   ibri_top dut_u (.clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .irq, .dio_n_in, .dav_n_in, .nrfd_n_in, .ndac_n_in, .eoi_n_in, .atn_n_in, .ifc_n_in,
      .ren_n_in, .od_level, .dio_oe, .dav_oe, .nrfd_oe, .ndac_oe, .eoi_oe, .srq_oe, .panel_key_valid,
      .panel_key_local, .compat_toggle, .lang_toggle, .panel_key_pass, .remote_led, .lockout, .compat_mode,
      .cmd_lang, .module_reset);
   ibri_host host_u (.clock, .dio_oe, .dav_oe, .nrfd_oe, .ndac_oe, .eoi_oe, .dio_n_in, .dav_n_in,
      .nrfd_n_in, .ndac_n_in, .eoi_n_in, .atn_n_in, .ren_n_in);
   always #50 clock = ~clock;
   always @(posedge clock) begin
      if (module_reset === 1'b1) mr_seen <= 1'b1;
      if (panel_key_pass === 1'b1) kp_seen <= 1'b1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clock);
   endtask : bus
   // k: 0 key valid, 1 compat toggle, 2 language toggle
   task automatic pulse(input int k);
      {lang_toggle, compat_toggle, panel_key_valid} <= 3'(1 << k);
      @(posedge clock);
      {lang_toggle, compat_toggle, panel_key_valid} <= 3'b000;
      repeat (2) @(posedge clock);
   endtask : pulse
   task automatic cmd(input logic [6:0] c);
      host_u.send({1'b0, c}, 1'b1, 1'b0);
   endtask : cmd
   task automatic t_reset();
      bus(0, OFF_CTRL, 0);
      chk(rd, 32'h01);
      bus(0, OFF_ENMASK, 0);
      chk(rd, 32'(MASK_INIT_OFF));
      bus(0, 8'h24, 0);
      chk(rd, 32'h0);
      pulse(1);
      pulse(2);
      bus(0, OFF_CTRL, 0);
      chk(rd, 32'h61);
   endtask : t_reset
   task automatic t_remote();
      host_u.h_ren <= 1'b1;
      cmd(LAD_BASE | 7'h01);
      bus(0, OFF_STATUS, 0);
      chk(rd, 32'h00d);
      pulse(0);
      chk(kp_seen, 0);
      cmd(CMD_LLO);
      panel_key_local <= 1'b1;
      pulse(0);
      chk({od_level, lockout, remote_led}, 3'b011);
      cmd(CMD_GTL);
      kp_seen <= 1'b0;
      pulse(0);
      chk({kp_seen, remote_led}, 2'b10);
   endtask : t_remote
   task automatic t_line();
      bus(1, OFF_EVENT, 32'h3f);
      bus(1, OFF_IMASK, 32'h02);
      host_u.send(8'h41, 1'b0, 1'b0);
      chk(irq, 0);
      bus(0, OFF_RXDATA, 0);
      chk(rd, 32'h241);
      host_u.send(CHAR_CR, 1'b0, 1'b0);
      bus(0, OFF_RXDATA, 0);
      chk(rd, 32'h30d);
      bus(0, OFF_RXDATA, 0);
      chk(rd, 32'h30a);
      host_u.send(8'h42, 1'b0, 1'b1);
      bus(0, OFF_RXDATA, 0);
      chk(rd, 32'h342);
      bus(0, OFF_RXDATA, 0);
      chk({rd[9:0], irq}, 11'h615);
      bus(1, OFF_EVENT, 32'h3f);
      @(posedge clock);
      chk(irq, 0);
   endtask : t_line
   task automatic t_clear();
      mr_seen <= 1'b0;
      cmd(CMD_DCL);
      chk(mr_seen, 1);
      pulse(1);
      bus(1, OFF_EVENT, 32'h3f);
      mr_seen <= 1'b0;
      cmd(CMD_SDC);
      bus(0, OFF_EVENT, 0);
      chk({mr_seen, rd[EV_DCLR]}, 2'b01);
   endtask : t_clear
   task automatic t_talk();
      cmd(TAD_BASE | 7'h01);
      bus(0, OFF_STATUS, 0);
      chk(rd & 32'h6, 32'h2);
      bus(1, OFF_TXDATA, 32'h155);
      bus(0, OFF_STB, 0);
      chk(rd[STB_MAV], 1);
      host_u.recv(b, e);
      chk({e, b}, 9'h155);
      bus(1, OFF_STB, 32'h02);
      bus(1, OFF_SRE, 32'h02);
      @(posedge clock);
      chk(srq_oe, 1);
      cmd(CMD_SPE);
      host_u.recv(b, e);
      chk(b, 8'h42);
      cmd(CMD_SPD);
      bus(1, OFF_SRE, 0);
      @(posedge clock);
      chk(srq_oe, 0);
      cmd(LAD_BASE | 7'h01);
      bus(0, OFF_STATUS, 0);
      chk(rd & 32'h6, 32'h4);
   endtask : t_talk
   task automatic report_and_stop();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset();
      t_remote();
      t_line();
      t_clear();
      t_talk();
      report_and_stop();
   end
   initial begin
      #5_000_000;
      failures++;
      report_and_stop();
   end
endmodule : ibri_top_bench
`default_nettype wire

/* File: logic/ibri_pkg.sv */
// constants and state codes of the remote interface
// assumes a single 10 MHz clock and synchronous active-low reset
package ibri_pkg;

   localparam int CLK_HZ     = 10_000_000;
   // data settle time before data valid
   localparam int SETTLE_NS  = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);

   // register byte addresses
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_RXDATA = 8'h08;
   localparam logic [7:0] OFF_TXDATA = 8'h0c;
   localparam logic [7:0] OFF_STB    = 8'h10;
   localparam logic [7:0] OFF_SRE    = 8'h14;
   localparam logic [7:0] OFF_EVENT  = 8'h18;
   localparam logic [7:0] OFF_IMASK  = 8'h1c;
   localparam logic [7:0] OFF_ENMASK = 8'h20;

   // values after reset
   localparam logic [4:0]  ADDR_RST      = 5'h01;
   localparam logic        COMPAT_RST    = 1'b0;
   localparam logic        LANG_RST      = 1'b0;
   localparam logic [14:0] MASK_INIT_OFF = 15'h0000;
   localparam logic [14:0] MASK_INIT_ON  = 15'h7fff;

   // bus commands under attention, low seven bits
   localparam logic [6:0] CMD_GTL  = 7'h01;
   localparam logic [6:0] CMD_SDC  = 7'h04;
   localparam logic [6:0] CMD_LLO  = 7'h11;
   localparam logic [6:0] CMD_DCL  = 7'h14;
   localparam logic [6:0] CMD_SPE  = 7'h18;
   localparam logic [6:0] CMD_SPD  = 7'h19;
   localparam logic [6:0] CMD_UNL  = 7'h3f;
   localparam logic [6:0] CMD_UNT  = 7'h5f;
   localparam logic [6:0] LAD_BASE = 7'h20;
   localparam logic [6:0] TAD_BASE = 7'h40;

   localparam logic [7:0] CHAR_LF = 8'h0a;
   localparam logic [7:0] CHAR_CR = 8'h0d;

   // status byte bit positions
   localparam int STB_ISUM = 0;
   localparam int STB_MAV  = 4;
   localparam int STB_RQS  = 6;

   // event bit positions
   localparam int EV_RX    = 0;
   localparam int EV_LINE  = 1;
   localparam int EV_DCLR  = 2;
   localparam int EV_TXOK  = 3;
   localparam int EV_REM   = 4;
   localparam int EV_SPOLL = 5;
   localparam int EV_W     = 6;

   typedef enum logic [3:0] {
      AH_IDLE  = 4'b0001,
      AH_READY = 4'b0010,
      AH_TAKEN = 4'b0100,
      AH_WAIT  = 4'b1000
   } ibri_ah_t;

   typedef enum logic [2:0] {
      SH_IDLE   = 3'b001,
      SH_SETTLE = 3'b010,
      SH_WAIT   = 3'b100
   } ibri_sh_t;

endpackage : ibri_pkg

/* File: logic/ibri_sync.sv */
// two-flop synchroniser for the bus pin inputs
// assumes inputs are asynchronous levels; idle bus lines are high
`timescale 1ns/100ps
`default_nettype none
module ibri_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] IDLE = '1
) (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         meta <= IDLE;
         q    <= IDLE;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : ibri_sync
`default_nettype wire

/* File: logic/ibri_top.sv */
// talker/listener end of the instrument bus with register slave
// assumes active-low asynchronous open-drain bus pins; panel inputs on clock
//
// Behaviour
// - two-value compatibility setting, toggled locally
// - device clear resets power modules only in compatibility mode
// - instrument summary reaches status byte only with compatibility off
// - power-on enable mask is 0; compatibility mode is always off when the mask loads after reset
// - command language selection is held for the parser
// - full source and acceptor three-wire handshakes, byte by byte
// - talker, serial poll, unaddressed by own listen address
// - listener, unaddressed by own talk address
// - service request line driven while an enabled condition exists
// - local mode runs panel keys; own listen address makes it remote
// - in remote, light indicator and block all keys except local
// - local lockout also blocks the local key until controller or power-on
// - universal and selected device clear both act as device clear
// - line ends on end flag, CR or LF; a line feed is then appended unless the last byte was LF
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ibri_top
   import ibri_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   output var  logic        irq,
   input  wire logic [7:0]  dio_n_in,
   input  wire logic        dav_n_in,
   input  wire logic        nrfd_n_in,
   input  wire logic        ndac_n_in,
   input  wire logic        eoi_n_in,
   input  wire logic        atn_n_in,
   input  wire logic        ifc_n_in,
   input  wire logic        ren_n_in,
   output var  logic        od_level,
   output var  logic [7:0]  dio_oe,
   output var  logic        dav_oe,
   output var  logic        nrfd_oe,
   output var  logic        ndac_oe,
   output var  logic        eoi_oe,
   output var  logic        srq_oe,
   input  wire logic        panel_key_valid,
   input  wire logic        panel_key_local,
   input  wire logic        compat_toggle,
   input  wire logic        lang_toggle,
   output var  logic        panel_key_pass,
   output var  logic        remote_led,
   output var  logic        lockout,
   output var  logic        compat_mode,
   output var  logic        cmd_lang,
   output var  logic        module_reset
);
   import ibri_pkg::*;

   function automatic logic [6:0] addr_cmd(input logic [6:0] base, input logic [4:0] a);
      addr_cmd = base | {2'b00, a};
   endfunction : addr_cmd

   function automatic logic is_term(input logic [7:0] b);
      is_term = (b == CHAR_LF) || (b == CHAR_CR);
   endfunction : is_term

   logic [14:0]       pin_q;
   logic [4:0]        my_addr;
   logic              talker;
   logic              listener;
   logic              spe;
   logic              remote_d;
   logic [7:0]        rx_byte;
   logic              rx_end;
   logic              rx_full;
   logic              lf_pending;
   logic [7:0]        tx_byte;
   logic              tx_eoi;
   logic              tx_full;
   logic              sh_poll;
   logic [7:0]        stb_sw;
   logic [7:0]        sre;
   logic [14:0]       en_mask;
   logic [EV_W-1:0]   ev;
   logic [EV_W-1:0]   ev_mask;
   logic [EV_W-1:0]   ev_set;
   logic              por_done;
   logic              rd_pop;
   logic [31:0]       rd_mux;
   logic [7:0]        cap_byte;
   logic              cap_eoi;
   logic              cap_atn;
   logic [7:0]        settle_cnt;
   ibri_ah_t          ah_state;
   ibri_sh_t          sh_state;

   ibri_sync #(.W(15)) u_sync (
      .clock (clock),
      .rstn  (rstn),
      .d     ({ren_n_in, ifc_n_in, atn_n_in, eoi_n_in, ndac_n_in, nrfd_n_in, dav_n_in, dio_n_in}),
      .q     (pin_q)
   );

   // bus lines are active low; these are the asserted senses
   wire logic [7:0] bus_data = ~pin_q[7:0];
   wire logic       dav      = ~pin_q[8];
   wire logic       nrfd     = ~pin_q[9];
   wire logic       ndac     = ~pin_q[10];
   wire logic       eoi      = ~pin_q[11];
   wire logic       atn      = ~pin_q[12];
   wire logic       ifc      = ~pin_q[13];
   wire logic       ren      = ~pin_q[14];

   wire logic       req      = avs_read | avs_write;
   wire logic       take     = req & ~avs_waitrequest;
   wire logic       wr       = take & avs_write;
   wire logic       got      = (ah_state == AH_TAKEN);
   wire logic       cmd      = got & cap_atn;
   wire logic [6:0] cbyte    = cap_byte[6:0];
   wire logic       rx_room  = ~rx_full & ~lf_pending;
   wire logic       ah_on    = atn | listener;
   wire logic       sh_abort = atn | ~talker | ifc;
   wire logic       sh_sent  = (sh_state == SH_WAIT) & ~ndac & ~sh_abort;
   wire logic       pop      = take & avs_read & rd_pop;
   wire logic       dclr     = cmd & ((cbyte == CMD_DCL) | ((cbyte == CMD_SDC) & listener));
   wire logic       data_in  = got & ~cap_atn & listener;

   // instrument summary dropped in compatibility mode
   // data-available bit follows the pending response byte
   logic [7:0] stb_core;
   always_comb begin
      stb_core = stb_sw;
      stb_core[STB_RQS] = 1'b0;
      stb_core[STB_MAV] = tx_full;
      if (compat_mode) begin
         stb_core[STB_ISUM] = 1'b0;
      end
   end
   wire logic srq_cond = |(stb_core & sre);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         compat_mode <= COMPAT_RST;
         cmd_lang    <= LANG_RST;
      end else begin
         if (compat_toggle) begin
            compat_mode <= ~compat_mode;
         end
         if (lang_toggle) begin
            cmd_lang <= ~cmd_lang;
         end
      end
   end

   // mask load just after reset, per current mode
   always_ff @(posedge clock) begin
      if (!rstn) begin
         por_done <= 1'b0;
         en_mask  <= MASK_INIT_OFF;
      end else if (!por_done) begin
         por_done <= 1'b1;
         en_mask  <= compat_mode ? MASK_INIT_ON : MASK_INIT_OFF;
      end else if (wr && avs_address == OFF_ENMASK) begin
         en_mask <= avs_writedata[14:0];
      end
   end

   // commands never wait; data waits for room
   // acceptor handshake
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ah_state <= AH_IDLE;
         nrfd_oe  <= 1'b0;
         ndac_oe  <= 1'b0;
         cap_byte <= 8'h00;
         cap_eoi  <= 1'b0;
         cap_atn  <= 1'b0;
      end else begin
         case (ah_state)
            AH_IDLE: begin
               if (!ah_on) begin
                  nrfd_oe <= 1'b0;
                  ndac_oe <= 1'b0;
               end else if (atn || rx_room) begin
                  ndac_oe  <= 1'b1;
                  nrfd_oe  <= 1'b0;
                  ah_state <= AH_READY;
               end else begin
                  ndac_oe <= 1'b1;
                  nrfd_oe <= 1'b1;
               end
            end
            AH_READY: begin
               if (!ah_on || (!atn && !rx_room)) begin
                  nrfd_oe  <= ah_on;
                  ah_state <= AH_IDLE;
               end else if (dav) begin
                  nrfd_oe  <= 1'b1;
                  cap_byte <= bus_data;
                  cap_eoi  <= eoi;
                  cap_atn  <= atn;
                  ah_state <= AH_TAKEN;
               end
            end
            AH_TAKEN: begin
               ndac_oe  <= 1'b0;
               ah_state <= AH_WAIT;
            end
            AH_WAIT: begin
               if (!dav) begin
                  ndac_oe  <= ah_on;
                  ah_state <= AH_IDLE;
               end
            end
            default: ah_state <= AH_IDLE;
         endcase
      end
   end

   // addressing and serial poll state
   always_ff @(posedge clock) begin
      if (!rstn || ifc) begin
         talker   <= 1'b0;
         listener <= 1'b0;
         spe      <= 1'b0;
      end else if (cmd) begin
         if (cbyte == addr_cmd(LAD_BASE, my_addr)) begin
            listener <= 1'b1;
            talker   <= 1'b0;
         end else if (cbyte == addr_cmd(TAD_BASE, my_addr)) begin
            talker   <= 1'b1;
            listener <= 1'b0;
         end else if (cbyte == CMD_UNL) begin
            listener <= 1'b0;
         end else if (cbyte[6:5] == 2'b10) begin
            // other talk address or untalk
            talker <= 1'b0;
         end else if (cbyte == CMD_SPE) begin
            spe <= 1'b1;
         end else if (cbyte == CMD_SPD) begin
            spe <= 1'b0;
         end
      end
   end

   // remote enable low overrides everything
   always_ff @(posedge clock) begin
      if (!rstn || !ren) begin
         remote_led <= 1'b0;
         lockout    <= 1'b0;
      end else begin
         if (cmd && cbyte == addr_cmd(LAD_BASE, my_addr)) begin
            remote_led <= 1'b1;
         end else if (cmd && cbyte == CMD_GTL && listener) begin
            remote_led <= 1'b0;
         end else if (panel_key_valid && panel_key_local && !lockout) begin
            // local key honoured only without lockout
            remote_led <= 1'b0;
         end
         if (cmd && cbyte == CMD_LLO) begin
            lockout <= 1'b1;
         end
      end
   end

   // keys reach the panel logic only in local
   // power module reset only in compatibility mode
   always_ff @(posedge clock) begin
      if (!rstn) begin
         panel_key_pass <= 1'b0;
         module_reset   <= 1'b0;
         srq_oe         <= 1'b0;
         remote_d       <= 1'b0;
         od_level       <= 1'b0;
      end else begin
         panel_key_pass <= panel_key_valid & ~remote_led;
         module_reset   <= dclr & compat_mode;
         srq_oe         <= srq_cond;
         remote_d       <= remote_led;
         od_level       <= 1'b0;
      end
   end

   // appended line feed reuses the receive slot
   always_ff @(posedge clock) begin
      if (!rstn || dclr) begin
         rx_byte    <= 8'h00;
         rx_end     <= 1'b0;
         rx_full    <= 1'b0;
         lf_pending <= 1'b0;
      end else if (data_in) begin
         rx_byte    <= cap_byte;
         rx_end     <= cap_eoi | is_term(cap_byte);
         rx_full    <= 1'b1;
         lf_pending <= (cap_eoi | is_term(cap_byte)) & (cap_byte != CHAR_LF);
      end else if (lf_pending && (!rx_full || pop)) begin
         rx_byte    <= CHAR_LF;
         rx_end     <= 1'b1;
         rx_full    <= 1'b1;
         lf_pending <= 1'b0;
      end else if (pop) begin
         rx_full <= 1'b0;
      end
   end

   // attention or untalk withdraws the byte
   // source handshake
   always_ff @(posedge clock) begin
      if (!rstn) begin
         sh_state   <= SH_IDLE;
         dio_oe     <= 8'h00;
         dav_oe     <= 1'b0;
         eoi_oe     <= 1'b0;
         sh_poll    <= 1'b0;
         settle_cnt <= 8'h00;
      end else if (sh_abort || sh_sent) begin
         sh_state <= SH_IDLE;
         dio_oe   <= 8'h00;
         dav_oe   <= 1'b0;
         eoi_oe   <= 1'b0;
      end else begin
         case (sh_state)
            SH_IDLE: begin
               if (spe || tx_full) begin
                  dio_oe     <= spe ? (stb_core | {1'b0, srq_cond, 6'h00}) : tx_byte;
                  eoi_oe     <= ~spe & tx_eoi;
                  sh_poll    <= spe;
                  settle_cnt <= SETTLE_LOAD;
                  sh_state   <= SH_SETTLE;
               end
            end
            SH_SETTLE: begin
               if (settle_cnt != 8'h00) begin
                  settle_cnt <= settle_cnt - 8'h01;
               end else if (!nrfd) begin
                  dav_oe   <= 1'b1;
                  sh_state <= SH_WAIT;
               end
            end
            SH_WAIT: sh_state <= SH_WAIT;
            default: sh_state <= SH_IDLE;
         endcase
      end
   end

   // transmit holding byte
   always_ff @(posedge clock) begin
      if (!rstn || dclr) begin
         tx_byte <= 8'h00;
         tx_eoi  <= 1'b0;
         tx_full <= 1'b0;
      end else if (wr && avs_address == OFF_TXDATA) begin
         tx_byte <= avs_writedata[7:0];
         tx_eoi  <= avs_writedata[8];
         tx_full <= 1'b1;
      end else if (sh_sent && !sh_poll) begin
         tx_full <= 1'b0;
      end
   end

   // software registers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         my_addr <= ADDR_RST;
         stb_sw  <= 8'h00;
         sre     <= 8'h00;
         ev_mask <= '0;
      end else if (wr) begin
         if (avs_address == OFF_CTRL) begin
            my_addr <= avs_writedata[4:0];
         end else if (avs_address == OFF_STB) begin
            stb_sw <= avs_writedata[7:0];
         end else if (avs_address == OFF_SRE) begin
            sre <= avs_writedata[7:0];
         end else if (avs_address == OFF_IMASK) begin
            ev_mask <= avs_writedata[EV_W-1:0];
         end
      end
   end

   // events: a set in the clearing cycle survives
   always_comb begin
      ev_set           = '0;
      ev_set[EV_RX]    = data_in;
      ev_set[EV_LINE]  = data_in & (cap_eoi | is_term(cap_byte));
      ev_set[EV_DCLR]  = dclr;
      ev_set[EV_TXOK]  = sh_sent & ~sh_poll;
      ev_set[EV_REM]   = remote_led ^ remote_d;
      ev_set[EV_SPOLL] = sh_sent & sh_poll;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ev  <= '0;
         irq <= 1'b0;
      end else begin
         if (wr && avs_address == OFF_EVENT) begin
            ev <= (ev & ~avs_writedata[EV_W-1:0]) | ev_set;
         end else begin
            ev <= ev | ev_set;
         end
         irq <= |(ev & ev_mask);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (avs_address == OFF_CTRL) begin
         rd_mux[6:0] = {cmd_lang, compat_mode, my_addr};
      end else if (avs_address == OFF_STATUS) begin
         rd_mux[9:0] = {srq_cond, tx_full, lf_pending, rx_full, spe, lockout, remote_led, listener, talker,
                        ren};
      end else if (avs_address == OFF_RXDATA) begin
         rd_mux[9:0] = {rx_full, rx_end, rx_byte};
      end else if (avs_address == OFF_STB) begin
         rd_mux[7:0] = stb_core | {1'b0, srq_cond, 6'h00};
      end else if (avs_address == OFF_SRE) begin
         rd_mux[7:0] = sre;
      end else if (avs_address == OFF_EVENT) begin
         rd_mux[EV_W-1:0] = ev;
      end else if (avs_address == OFF_IMASK) begin
         rd_mux[EV_W-1:0] = ev_mask;
      end else if (avs_address == OFF_ENMASK) begin
         rd_mux[14:0] = en_mask;
      end
   end

   // one wait cycle; transmit write stalls while a byte is pending
   always_ff @(posedge clock) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         rd_pop          <= 1'b0;
      end else if (req && avs_waitrequest && !(avs_write && avs_address == OFF_TXDATA && tx_full)) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
         rd_pop          <= avs_read && avs_address == OFF_RXDATA && rx_full;
      end else begin
         avs_waitrequest <= 1'b1;
         rd_pop          <= 1'b0;
      end
   end

endmodule : ibri_top
`default_nettype wire
